// File: iopw_cfg.svh
`ifndef IOPW_CFG_SVH
`define IOPW_CFG_SVH
// Byte offsets of software registers
`define IOPW_OFF_BITCMD   32'h0000_0000
`define IOPW_OFF_STATUS   32'h0000_0004
`define IOPW_OFF_LATCH    32'h0000_0008
// Bit command register fields
`define IOPW_CMD_ADDR_LSB 0
`define IOPW_CMD_ADDR_MSB 11
`define IOPW_CMD_DATA_BIT 12
`define IOPW_CMD_READ_BIT 13
// Status fields
`define IOPW_ST_RDATA_BIT 0
`define IOPW_ST_HOLD_BIT  1
`define IOPW_ST_TO1_BIT   2
`define IOPW_ST_TO2_BIT   3
// Reset values
`define IOPW_LATCH_RST    8'h00
// Timing
`define IOPW_TO1_MS       20
`define IOPW_TO2_MS       10
`define IOPW_CLK_KHZ      10000
`define IOPW_TO1_CYC      (`IOPW_TO1_MS * `IOPW_CLK_KHZ)
`define IOPW_TO2_CYC      (`IOPW_TO2_MS * `IOPW_CLK_KHZ)
`endif

// File: iopw_pkg.sv
package iopw_pkg;
    typedef enum logic [1:0]
    {
        IOPW_WD_RUN1 = 2'b00,
        IOPW_WD_RUN2 = 2'b01,
        IOPW_WD_DONE = 2'b11
    } iopw_wd_state_t;
    typedef enum logic [1:0]
    {
        IOPW_FN_PORT  = 2'b00,
        IOPW_FN_TIMER = 2'b01,
        IOPW_FN_CLEAR = 2'b10,
        IOPW_FN_NONE  = 2'b11
    } iopw_fn_t;
endpackage

// File: iopw_decode.sv
`include "iopw_cfg.svh"
module iopw_decode
(
    input  wire logic [11:0]    bit_addr,
    input  wire logic [7:0]     board_select_straps,
    output logic                board_hit,
    output iopw_pkg::iopw_fn_t  out_fn,
    output logic [2:0]          port_sel
);
    // Bit address index 11 is A3, index 0 is A14
    always_comb
    begin
        board_hit = (bit_addr[11:4] == board_select_straps);
        port_sel  = bit_addr[2:0];
        if (!board_hit)
            out_fn = iopw_pkg::IOPW_FN_NONE;
        else if (!bit_addr[3])
            out_fn = iopw_pkg::IOPW_FN_PORT;
        else if (!bit_addr[2])
            out_fn = iopw_pkg::IOPW_FN_TIMER;
        else
            out_fn = iopw_pkg::IOPW_FN_CLEAR;
    end
endmodule // iopw_decode

// File: iopw_watchdog.sv
`include "iopw_cfg.svh"
module iopw_watchdog
#(
    parameter int TO1_CYC = `IOPW_TO1_CYC,
    parameter int TO2_CYC = `IOPW_TO2_CYC
)
(
    input  wire logic  hclk,
    input  wire logic  hresetn,
    input  wire logic  retrigger,
    output logic       to1_pulse,
    output logic       to1_seen,
    output logic       to2_seen
);
    iopw_pkg::iopw_wd_state_t state_q, state_d;
    logic [31:0]              cnt_q, cnt_d;
    logic                     to1_q, to1_d;
    logic                     to2_q, to2_d;
    logic                     pulse_q, pulse_d;

    always_comb
    begin
        state_d = state_q;
        cnt_d   = cnt_q + 32'h0000_0001;
        to1_d   = to1_q;
        to2_d   = to2_q;
        pulse_d = 1'b0;
        if (retrigger)
        begin
            // Restart from first stage; hold is kept by the top
            state_d = iopw_pkg::IOPW_WD_RUN1;
            cnt_d   = 32'h0000_0000;
            to1_d   = 1'b0;
            to2_d   = 1'b0;
        end
        else
        begin
            case (state_q)
                iopw_pkg::IOPW_WD_RUN1:
                    if (cnt_q >= 32'(TO1_CYC - 1))
                    begin
                        state_d = iopw_pkg::IOPW_WD_RUN2;
                        cnt_d   = 32'h0000_0000;
                        to1_d   = 1'b1;
                        pulse_d = 1'b1;
                    end
                iopw_pkg::IOPW_WD_RUN2:
                    if (cnt_q >= 32'(TO2_CYC - 1))
                    begin
                        state_d = iopw_pkg::IOPW_WD_DONE;
                        to2_d   = 1'b1;
                    end
                default:
                    cnt_d = cnt_q;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state_q <= iopw_pkg::IOPW_WD_RUN1;
            cnt_q   <= 32'h0000_0000;
            to1_q   <= 1'b0;
            to2_q   <= 1'b0;
            pulse_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            to1_q   <= to1_d;
            to2_q   <= to2_d;
            pulse_q <= pulse_d;
        end
    end

    assign to1_pulse = pulse_q;
    assign to1_seen  = to1_q;
    assign to2_seen  = to2_q;
endmodule // iopw_watchdog

// File: iopw_top.sv
// Function
// - Act only when address bits A3..A10 match the board select straps.
// - A12..A14 pick one of eight ports, echo bits or constant bits.
// - Write with A11 low loads the selected port latch; high selects auxiliary.
// - With A11 high, ignore A13/A14; A12 splits timer set from clear.
// - Writing one closes a port switch; zero opens it.
// - Writes at displacements 08..0B retrigger the watchdog.
// - Writes at displacements 0C..0F clear all eight latches.
// - Reads at 00..07 return the echo-back of that port.
// - Reads at 08..0F return constant straps one to eight; fitted reads zero.
// - Constant bit one is ANDed with not-second-timeout.
// - Second timeout comes 10 ms after the first without retrigger.
// - Hold strap set: second timeout drives grant-pass-out low.
// - Watchdog starts counting at reset and on retrigger.
// - First timeout comes 20 ms after last set or reset.
// - Strap selects whether first timeout opens all outputs.
// - Strap selects power-fail, non-maskable or no interrupt on first timeout.
//
// Our own choices: the register offsets and the AHB-Lite slave port.
`include "iopw_cfg.svh"
module iopw_top
#(
    parameter int TO1_CYC = `IOPW_TO1_CYC,
    parameter int TO2_CYC = `IOPW_TO2_CYC
)
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire logic [7:0]  board_select_straps,
    input  wire logic [7:0]  constant_value_straps,
    input  wire logic        hold_option_strap,
    input  wire logic [1:0]  timeout_interrupt_strap,
    input  wire logic        timeout_output_clear_strap,
    input  wire logic [7:0]  echo_back_in,
    input  wire logic        bus_grant_pass_in,
    output logic [7:0]       port_switch_close,
    output logic             power_fail_interrupt,
    output logic             nmi_interrupt,
    output logic             bus_grant_pass_out
);
    ////////////////////////////////////////////////////////////////////////////////
    // Bus slave: address phase capture
    logic        wr_pend_q, wr_pend_d;
    logic        rd_pend_q, rd_pend_d;
    logic [31:0] addr_q, addr_d;
    logic [31:0] rdata_q, rdata_d;
    logic        take;

    assign take = hsel && hready && htrans[1];

    always_comb
    begin
        wr_pend_d = 1'b0;
        rd_pend_d = 1'b0;
        addr_d    = addr_q;
        if (take)
        begin
            wr_pend_d = hwrite;
            rd_pend_d = !hwrite;
            addr_d    = haddr;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Bit command issued by a write to the command register
    logic        cmd_go;
    logic [11:0] cmd_addr;
    logic        cmd_data;
    logic        cmd_read;
    logic        hit;
    logic [2:0]  sel;
    iopw_pkg::iopw_fn_t fn;

    assign cmd_go   = wr_pend_q && (addr_q == `IOPW_OFF_BITCMD);
    assign cmd_addr = hwdata[`IOPW_CMD_ADDR_MSB:`IOPW_CMD_ADDR_LSB];
    assign cmd_data = hwdata[`IOPW_CMD_DATA_BIT];
    assign cmd_read = hwdata[`IOPW_CMD_READ_BIT];

    iopw_decode u_decode
    (
        .bit_addr            (cmd_addr),
        .board_select_straps (board_select_straps),
        .board_hit           (hit),
        .out_fn              (fn),
        .port_sel            (sel)
    );

    logic bit_wr;
    logic bit_rd;
    logic retrig;
    logic to1_pulse;
    logic to1_seen;
    logic to2_seen;

    assign bit_wr = cmd_go && !cmd_read;
    assign bit_rd = cmd_go && cmd_read && hit;
    assign retrig = bit_wr && (fn == iopw_pkg::IOPW_FN_TIMER);

    iopw_watchdog #(.TO1_CYC(TO1_CYC), .TO2_CYC(TO2_CYC)) u_wd
    (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .retrigger (retrig),
        .to1_pulse (to1_pulse),
        .to1_seen  (to1_seen),
        .to2_seen  (to2_seen)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Output latches, read bit, hold
    logic [7:0] latch_q, latch_d;
    logic       rbit_q, rbit_d;
    logic       hold_q, hold_d;
    logic       rvalue;

    always_comb
    begin
        latch_d = latch_q;
        if (bit_wr && fn == iopw_pkg::IOPW_FN_PORT)
            latch_d[sel] = cmd_data;
        if (bit_wr && fn == iopw_pkg::IOPW_FN_CLEAR)
            latch_d = `IOPW_LATCH_RST;
        // Timeout clear wins over a write in the same cycle
        if (to1_pulse && timeout_output_clear_strap)
            latch_d = `IOPW_LATCH_RST;
    end

    always_comb
    begin
        if (!cmd_addr[3])
            rvalue = echo_back_in[cmd_addr[2:0]];
        else if (cmd_addr[2:0] == 3'h0)
            rvalue = constant_value_straps[0] & !to2_seen;
        else
            rvalue = constant_value_straps[cmd_addr[2:0]];
        rbit_d = bit_rd ? rvalue : rbit_q;
        // Sticky until reset; retrigger cannot release
        hold_d = hold_q || (to2_seen && hold_option_strap);
    end

    always_comb
    begin
        rdata_d = 32'h0000_0000;
        if (take && !hwrite)
        begin
            if (haddr == `IOPW_OFF_STATUS)
            begin
                rdata_d[`IOPW_ST_RDATA_BIT] = rbit_q;
                rdata_d[`IOPW_ST_HOLD_BIT]  = hold_q;
                rdata_d[`IOPW_ST_TO1_BIT]   = to1_seen;
                rdata_d[`IOPW_ST_TO2_BIT]   = to2_seen;
            end
            else if (haddr == `IOPW_OFF_LATCH)
                rdata_d[7:0] = latch_q;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            addr_q    <= 32'h0000_0000;
            rdata_q   <= 32'h0000_0000;
            latch_q   <= `IOPW_LATCH_RST;
            rbit_q    <= 1'b1;
            hold_q    <= 1'b0;
        end
        else
        begin
            wr_pend_q <= wr_pend_d;
            rd_pend_q <= rd_pend_d;
            addr_q    <= addr_d;
            rdata_q   <= rdata_d;
            latch_q   <= latch_d;
            rbit_q    <= rbit_d;
            hold_q    <= hold_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs
    assign hreadyout         = 1'b1;
    assign hresp             = 1'b0;
    assign hrdata            = rdata_q;
    assign port_switch_close = latch_q;
    // Strap 01 power fail, 10 non-maskable, else none
    assign power_fail_interrupt = to1_seen && (timeout_interrupt_strap == 2'b01);
    assign nmi_interrupt        = to1_seen && (timeout_interrupt_strap == 2'b10);
    assign bus_grant_pass_out   = bus_grant_pass_in && !hold_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks
    sequence s_clear_cmd;
        bit_wr && fn == iopw_pkg::IOPW_FN_CLEAR && !to1_pulse;
    endsequence

    a_clear_all: assert property (@(posedge hclk) disable iff (!hresetn)
        s_clear_cmd |=> port_switch_close == 8'h00)
        else $error("clear did not open all ports");
    a_port_write: assert property (@(posedge hclk) disable iff (!hresetn)
        bit_wr && fn == iopw_pkg::IOPW_FN_PORT && !to1_pulse
        |=> port_switch_close[$past(sel)] == $past(cmd_data))
        else $error("port latch not written");
    a_foreign_board: assert property (@(posedge hclk) disable iff (!hresetn)
        bit_wr && !hit && !to1_pulse |=> $stable(port_switch_close))
        else $error("other board address changed latches");
    a_hold_sticky: assert property (@(posedge hclk) disable iff (!hresetn)
        !bus_grant_pass_out && bus_grant_pass_in |=> !bus_grant_pass_out)
        else $error("hold released without reset");
    a_hold_set: assert property (@(posedge hclk) disable iff (!hresetn)
        to2_seen && hold_option_strap |=> !bus_grant_pass_out)
        else $error("hold not asserted");
    a_no_hold: assert property (@(posedge hclk) disable iff (!hresetn)
        !hold_option_strap throughout (!hold_q ##1 1) |-> !hold_q)
        else $error("hold without strap");
    a_to_clear: assert property (@(posedge hclk) disable iff (!hresetn)
        to1_pulse && timeout_output_clear_strap |=> port_switch_close == 8'h00)
        else $error("timeout did not open outputs");
    a_strap_read: assert property (@(posedge hclk) disable iff (!hresetn)
        bit_rd && cmd_addr[3] && cmd_addr[2:0] != 3'h0
        |=> rbit_q == $past(constant_value_straps[cmd_addr[2:0]]))
        else $error("constant strap misread");
    a_to2_flag: assert property (@(posedge hclk) disable iff (!hresetn)
        bit_rd && cmd_addr[3:0] == 4'h8 && to2_seen |=> !rbit_q)
        else $error("second timeout not seen on bit one");
    a_retrigger: assert property (@(posedge hclk) disable iff (!hresetn)
        retrig |=> !u_wd.to1_seen && !u_wd.to2_seen)
        else $error("retrigger did not restart watchdog");
endmodule // iopw_top

// File: iopw_load_model.sv
module iopw_load_model
(
    input  wire logic       hclk,
    input  wire logic [7:0] port_switch_close,
    output logic [7:0]      echo_back_in,
    output logic            bus_grant_pass_in
);
    timeunit 1ns;
    timeprecision 1ns;
    initial echo_back_in = 8'h00;
    // Echo lags the latch by a cycle, like a contact settling
    always @(posedge hclk)
    begin
        echo_back_in <= port_switch_close;
    end
    // No two ports share a load here, so single bit writes are safe
    // Grant chain from upstream is always passed on
    assign bus_grant_pass_in = 1'b1;
endmodule // iopw_load_model

// File: iopw_top_tb_top.sv
`include "iopw_cfg.svh"
module iopw_top_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int         TO1 = 300;
    localparam int         TO2 = 100;
    localparam logic [7:0] BRD = 8'h08;
    localparam logic [7:0] CST = 8'hA5;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0]  htrans = 2'b00;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0000_0000;
    logic        hreadyout, hresp, power_fail_interrupt, nmi_interrupt;
    logic        bus_grant_pass_out, bus_grant_pass_in;
    logic [31:0] hrdata, r;
    logic [7:0]  port_switch_close, echo_back_in, ex;
    logic        hold_s = 1'b1;
    logic        clr_s = 1'b1;
    logic [1:0]  irq_s = 2'b01;
    logic        v;
    int          err_count = 0;
    int          compares = 0;
    int          cyc = 0;

    always #50 hclk = ~hclk;

    iopw_top #(.TO1_CYC(TO1), .TO2_CYC(TO2)) i_iopw_top (
        .hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .board_select_straps(BRD), .constant_value_straps(CST),
        .hold_option_strap(hold_s), .timeout_interrupt_strap(irq_s),
        .timeout_output_clear_strap(clr_s), .echo_back_in(echo_back_in),
        .bus_grant_pass_in(bus_grant_pass_in), .port_switch_close(port_switch_close),
        .power_fail_interrupt(power_fail_interrupt), .nmi_interrupt(nmi_interrupt),
        .bus_grant_pass_out(bus_grant_pass_out));

    iopw_load_model i_iopw_load_model (
        .hclk(hclk), .port_switch_close(port_switch_close),
        .echo_back_in(echo_back_in), .bus_grant_pass_in(bus_grant_pass_in));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop();
        $display("Checks %0d, mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Hang guard, well above the longest expected run
    always @(posedge hclk)
    begin
        cyc++;
        if (cyc == 8000)
        begin
            err_count++;
            report_and_stop();
        end
    end

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e)
        begin
            err_count++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge hclk);
        @(negedge hclk);
    endtask

    task automatic do_reset();
        @(posedge hclk);
        hresetn <= 1'b0;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
    endtask

    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        @(posedge hclk);
        haddr  <= a;
        htrans <= 2'b10;
        hwrite <= wr;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'b00;
        hwdata <= wd;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask

    task automatic bit_wr(input logic [7:0] b, input logic [3:0] d, input logic x);
        logic [31:0] t;
        ahb(1'b1, `IOPW_OFF_BITCMD, {18'h0, 1'b0, x, b, d}, t);
    endtask

    task automatic bit_rd(input logic [3:0] d, output logic x);
        logic [31:0] t;
        ahb(1'b1, `IOPW_OFF_BITCMD, {18'h0, 1'b1, 1'b0, BRD, d}, t);
        ahb(1'b0, `IOPW_OFF_STATUS, 32'h0000_0000, t);
        x = t[0];
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        ex = 8'h00;
        do_reset();
        ahb(1'b0, `IOPW_OFF_LATCH, 32'h0000_0000, r);
        chk("latch reset", 32'h0000_0000, r);
        chk("grant reset", 32'h0000_0001, bus_grant_pass_out);
        chk("okay response", 32'h0000_0000, hresp);
        for (int p = 0; p < 8; p++)
        begin
            bit_wr(BRD, p[3:0], 1'b1);
            ex[p] = 1'b1;
            wait_cyc(0);
            chk("ports", ex, port_switch_close);
            bit_rd(p[3:0], v);
            chk("echo", 32'h0000_0001, v);
            bit_wr(BRD ^ 8'h01, p[3:0], 1'b0);
            wait_cyc(0);
            chk("other board", ex, port_switch_close);
        end
        bit_wr(BRD, 4'h3, 1'b0);
        bit_rd(4'h3, v);
        chk("echo open", 32'h0000_0000, v);
        $display("Test ports done");
        for (int d = 12; d < 16; d++)
        begin
            bit_wr(BRD, 4'h0, 1'b1);
            bit_wr(BRD, d[3:0], 1'b1);
            wait_cyc(0);
            chk("clear", 32'h0000_0000, port_switch_close);
        end
        for (int k = 0; k < 8; k++)
        begin
            bit_rd(4'h8 + k[3:0], v);
            chk("constant", CST[k], v);
        end
        // Each retrigger lands before the first timeout, but the sum exceeds it
        // Restart early so the gaps below are each shorter than the first timeout
        bit_wr(BRD, 4'h9, 1'b1);
        for (int d = 8; d < 12; d++)
        begin
            wait_cyc(TO1 - 60);
            chk("no early timeout", 32'h0000_0000, power_fail_interrupt);
            bit_wr(BRD, d[3:0], 1'b1);
        end
        wait_cyc(0);
        chk("no timeout", 32'h0000_0000, power_fail_interrupt);
        $display("Test functions done");
        for (int m = 0; m < 3; m++)
        begin
            @(posedge hclk);
            irq_s  <= (m == 0) ? 2'b01 : (m == 1) ? 2'b10 : 2'b00;
            hold_s <= (m != 2);
            clr_s  <= (m != 1);
            do_reset();
            bit_wr(BRD, 4'h1, 1'b1);
            bit_wr(BRD, 4'h8, 1'b1);
            wait_cyc(TO1 - 10);
            chk("irq early", 32'h0000_0000, {power_fail_interrupt, nmi_interrupt});
            wait_cyc(20);
            chk("irq", {irq_s == 2'b01, irq_s == 2'b10},
                {power_fail_interrupt, nmi_interrupt});
            chk("ports on timeout", clr_s ? 8'h00 : 8'h02, port_switch_close);
            // Hold lands one edge after the second stage ends
            wait_cyc(TO2 - 20);
            chk("grant early", 32'h0000_0001, bus_grant_pass_out);
            wait_cyc(20);
            chk("grant", !hold_s, bus_grant_pass_out);
            bit_rd(4'h8, v);
            chk("second flag", 32'h0000_0000, v);
            ahb(1'b0, `IOPW_OFF_STATUS, 32'h0000_0000, r);
            chk("status", {2'b11, hold_s}, r[3:1]);
            bit_wr(BRD, 4'hA, 1'b1);
            wait_cyc(1);
            chk("hold kept", !hold_s, bus_grant_pass_out);
            chk("irq cleared", 32'h0000_0000, {power_fail_interrupt, nmi_interrupt});
            $display("Test watchdog mode %0d done", m);
        end
        do_reset();
        wait_cyc(1);
        chk("grant after reset", 32'h0000_0001, bus_grant_pass_out);
        report_and_stop();
    end
endmodule // iopw_top_tb_top
